/* inc/cfg_bank_pkg.sv */
// constants, register indices and state codes of the paged register bank
// assumes a 100 MHz clock and APB byte addresses of four times the index
//
// Functional notes
// - page switches on write, page readable anytime
// - pages 0,1,2,3 and 0x0A to 0x0D decode
// - subordinate subsystems power up with master stage
// - master state codes 9, 0, 36 via 0x40
// - monitor state codes 5, 0, 12 via 0x40
// - input state codes 7, 0, 23 via 0x40
// - output state codes 12, 0, 20 via 0x60
// - PLL state codes 8, 0, 48 via 0x20
// - unmasked PLL live bit 0 shows unlock
// - outer loop bit 7 marks free-run profile
// - holdover view 0x0D shows holdover in bit 3
// - master 0x07 ones clear PLL lock/holdover notifies
// - monitor 0x03 ones clear clock loss notifies
// - monitor 0x07 ones clear drift notifies
// - notify bit sets only when its mask set
// - notify clears on written one, zero keeps
package cfg_bank_pkg;
  // ---------------------------------------------------------------
  // pages
  // ---------------------------------------------------------------
  localparam logic [7:0] PG_MASTER = 8'h00;
  localparam logic [7:0] PG_OUTPUT = 8'h03;
  localparam logic [7:0] PG_PLL_A = 8'h0A;
  localparam logic [7:0] PG_PLL_D = 8'h0D;
  localparam logic [2:0] PI_MASTER = 3'h0;
  localparam logic [2:0] PI_CLKMON = 3'h1;
  localparam logic [2:0] PI_INPUT = 3'h2;
  localparam logic [2:0] PI_OUTPUT = 3'h3;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IX_LIVE = 8'h02;
  localparam logic [7:0] IX_CL_STICKY = 8'h03;
  localparam logic [7:0] IX_MASK_A = 8'h04;
  localparam logic [7:0] IX_LIVE_B = 8'h06;
  localparam logic [7:0] IX_STICKY = 8'h07;
  localparam logic [7:0] IX_MASK_B = 8'h08;
  localparam logic [7:0] IX_OUTER = 8'h17;
  localparam logic [7:0] IX_COMMIT = 8'h30;
  localparam logic [7:0] IX_HO_SEL = 8'hB3;
  localparam logic [7:0] IX_HO_STAT = 8'hB9;
  localparam logic [7:0] IX_STATE = 8'hD0;
  localparam logic [7:0] IX_STATE_SEL = 8'hD1;
  localparam logic [7:0] IX_PAGE = 8'hFF;
  // ---------------------------------------------------------------
  // field values
  // ---------------------------------------------------------------
  localparam logic [7:0] SEL_GENERIC = 8'h40;
  localparam logic [7:0] SEL_OUTPUT = 8'h60;
  localparam logic [7:0] SEL_PLL = 8'h20;
  localparam logic [7:0] HO_VIEW = 8'h0D;
  localparam int HO_BIT = 3;
  localparam int FREE_RUN_BIT = 7;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] ST_IDLE = 8'h00;
  localparam logic [7:0] ST_M_WAIT = 8'h09;
  localparam logic [7:0] ST_M_ACT = 8'h24;
  localparam logic [7:0] ST_CM_WAIT = 8'h05;
  localparam logic [7:0] ST_CM_ACT = 8'h0C;
  localparam logic [7:0] ST_IN_WAIT = 8'h07;
  localparam logic [7:0] ST_IN_ACT = 8'h17;
  localparam logic [7:0] ST_OUT_WAIT = 8'h0C;
  localparam logic [7:0] ST_OUT_ACT = 8'h14;
  localparam logic [7:0] ST_PLL_WAIT = 8'h08;
  localparam logic [7:0] ST_PLL_ACT = 8'h30;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NVM_LOAD_NS = 10000;
  localparam int NVM_LOAD_CYC = (NVM_LOAD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  typedef enum logic [1:0] {SS_IDLE, SS_PROG_WAIT, SS_ACTIVE} ss_state_t;
endpackage : cfg_bank_pkg

/* inc/ss_ctl_if.sv */
// wake, commit and state of one subsystem sequencer
// assumes the bank drives wake and commit from its clock
`timescale 1ns/100ps
interface ss_ctl_if;
  logic wake;
  logic commit;
  cfg_bank_pkg::ss_state_t state;
  modport bank (output wake, output commit, input state);
  modport fsm (input wake, input commit, output state);
endinterface : ss_ctl_if

/* design/subsystem_fsm.sv */
// wake-up sequencer of one subsystem: idle, program wait, active
// assumes commit is a one-cycle pulse from the register bank
`timescale 1ns/100ps
module subsystem_fsm (
  input wire logic clk,
  input wire logic rst_n,
  ss_ctl_if.fsm ctl
);
  cfg_bank_pkg::ss_state_t state;
  cfg_bank_pkg::ss_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      cfg_bank_pkg::SS_IDLE: begin
        if (ctl.wake) next_state = cfg_bank_pkg::SS_PROG_WAIT;
      end
      cfg_bank_pkg::SS_PROG_WAIT: begin
        if (ctl.commit) next_state = cfg_bank_pkg::SS_ACTIVE;
      end
      default: next_state = state;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= cfg_bank_pkg::SS_IDLE;
    else state <= next_state;
  end

  assign ctl.state = state;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence wait_commit;
    state == cfg_bank_pkg::SS_PROG_WAIT && ctl.commit;
  endsequence
  fsm_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
    wait_commit |=> state == cfg_bank_pkg::SS_ACTIVE)
    else $error("commit in program wait did not activate");
  fsm_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == cfg_bank_pkg::SS_IDLE && !ctl.wake |=>
      state == cfg_bank_pkg::SS_IDLE)
    else $error("left idle without wake");
endmodule : subsystem_fsm

/* design/config_bank.sv */
// paged configuration and status bank behind an APB slave
// assumes live status inputs synchronous to CLK
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module config_bank (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] PLL_UNLOCK,
  input wire logic [3:0] PLL_HOLDOVER,
  input wire logic [3:0] CLOCK_LOSS,
  input wire logic [3:0] DRIFT_FINE,
  input wire logic [3:0] DRIFT_COARSE,
  output logic [7:0] SUBSYS_POWERED
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // {valid, slot}: slots 0..3 plain pages, 4..7 the PLL pages
  function automatic logic [3:0] page_slot(input logic [7:0] pg);
    logic [3:0] r;
    r = 4'h0;
    if (pg <= cfg_bank_pkg::PG_OUTPUT) r = {1'b1, pg[2:0]};
    else if (pg >= cfg_bank_pkg::PG_PLL_A && pg <= cfg_bank_pkg::PG_PLL_D)
      r = {2'b11, 2'(pg - cfg_bank_pkg::PG_PLL_A)};
    return r;
  endfunction : page_slot

  function automatic logic [7:0] sticky_next(input logic [7:0] old,
    input logic [7:0] ev, input logic [7:0] mask, input logic [7:0] clr);
    // a new event wins over a clear in the same cycle
    return (old & ~clr) | (ev & mask);
  endfunction : sticky_next

  function automatic logic [7:0] view_sel(input logic [2:0] s);
    logic [7:0] r;
    r = cfg_bank_pkg::SEL_GENERIC;
    if (s[2]) r = cfg_bank_pkg::SEL_PLL;
    else if (s == cfg_bank_pkg::PI_OUTPUT) r = cfg_bank_pkg::SEL_OUTPUT;
    return r;
  endfunction : view_sel

  function automatic logic [7:0] state_code(input logic [2:0] s,
    input cfg_bank_pkg::ss_state_t st);
    logic [7:0] w;
    logic [7:0] a;
    w = cfg_bank_pkg::ST_PLL_WAIT;
    a = cfg_bank_pkg::ST_PLL_ACT;
    if (s == cfg_bank_pkg::PI_MASTER) begin
      w = cfg_bank_pkg::ST_M_WAIT;
      a = cfg_bank_pkg::ST_M_ACT;
    end else if (s == cfg_bank_pkg::PI_CLKMON) begin
      w = cfg_bank_pkg::ST_CM_WAIT;
      a = cfg_bank_pkg::ST_CM_ACT;
    end else if (s == cfg_bank_pkg::PI_INPUT) begin
      w = cfg_bank_pkg::ST_IN_WAIT;
      a = cfg_bank_pkg::ST_IN_ACT;
    end else if (s == cfg_bank_pkg::PI_OUTPUT) begin
      w = cfg_bank_pkg::ST_OUT_WAIT;
      a = cfg_bank_pkg::ST_OUT_ACT;
    end
    if (st == cfg_bank_pkg::SS_PROG_WAIT) return w;
    else if (st == cfg_bank_pkg::SS_ACTIVE) return a;
    return cfg_bank_pkg::ST_IDLE;
  endfunction : state_code

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] page;
  logic [7:0] state_sel [8];
  logic [7:0] m_mask;
  logic [7:0] m_sticky;
  logic [3:0] cl_mask;
  logic [3:0] cl_sticky;
  logic [7:0] dr_mask;
  logic [7:0] dr_sticky;
  logic [7:0] pll_mask [4];
  logic [7:0] outer [4];
  logic [7:0] ho_sel [4];
  logic [11:0] load_cnt;
  logic load_done;
  cfg_bank_pkg::ss_state_t st [8];
  logic [7:0] rd_val;
  logic rd_ok;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [7:0] idx = PADDR[9:2];
  wire addr_ok = PADDR[1:0] == 2'h0 && PADDR[11:10] == 2'h0;
  wire [3:0] pdec = page_slot(page);
  wire pg_ok = pdec[3];
  wire [2:0] slot = pdec[2:0];
  wire on_m = pg_ok && slot == cfg_bank_pkg::PI_MASTER;
  wire on_cm = pg_ok && slot == cfg_bank_pkg::PI_CLKMON;
  wire on_pll = pg_ok && slot[2];
  wire [1:0] pll = slot[1:0];
  wire [7:0] wd = PWDATA[7:0];
  wire take = PSEL && PENABLE && !PREADY;
  wire wr_fire = PSEL && PENABLE && PWRITE && PREADY && addr_ok;
  wire w_page = wr_fire && idx == cfg_bank_pkg::IX_PAGE;
  wire w_sel = wr_fire && pg_ok && idx == cfg_bank_pkg::IX_STATE_SEL;
  wire w_commit = wr_fire && pg_ok && idx == cfg_bank_pkg::IX_COMMIT;
  wire w_m_mask = wr_fire && on_m && idx == cfg_bank_pkg::IX_MASK_B;
  wire w_m_clr = wr_fire && on_m && idx == cfg_bank_pkg::IX_STICKY;
  wire w_cl_mask = wr_fire && on_cm && idx == cfg_bank_pkg::IX_MASK_A;
  wire w_cl_clr = wr_fire && on_cm && idx == cfg_bank_pkg::IX_CL_STICKY;
  wire w_dr_mask = wr_fire && on_cm && idx == cfg_bank_pkg::IX_MASK_B;
  wire w_dr_clr = wr_fire && on_cm && idx == cfg_bank_pkg::IX_STICKY;
  wire w_p_mask = wr_fire && on_pll && idx == cfg_bank_pkg::IX_MASK_A;
  wire w_outer = wr_fire && on_pll && idx == cfg_bank_pkg::IX_OUTER;
  wire w_ho_sel = wr_fire && on_pll && idx == cfg_bank_pkg::IX_HO_SEL;
  wire [7:0] m_ev = {PLL_HOLDOVER, PLL_UNLOCK};
  wire [7:0] dr_ev = {DRIFT_COARSE, DRIFT_FINE};
  wire [7:0] m_clr = w_m_clr ? wd : 8'h00;
  wire [7:0] cl_clr = w_cl_clr ? {4'h0, wd[3:0]} : 8'h00;
  wire [7:0] dr_clr = w_dr_clr ? wd : 8'h00;
  wire [7:0] next_m_sticky = sticky_next(m_sticky, m_ev, m_mask, m_clr);
  wire [7:0] next_cl_sticky = sticky_next({4'h0, cl_sticky},
    {4'h0, CLOCK_LOSS}, {4'h0, cl_mask}, cl_clr);
  wire [7:0] next_dr_sticky = sticky_next(dr_sticky, dr_ev, dr_mask,
    dr_clr);
  // state view only answers with the selector that belongs to the page
  wire [7:0] state_rd = state_sel[slot] == view_sel(slot) ?
    state_code(slot, st[slot]) : cfg_bank_pkg::ST_IDLE;
  wire lol_live = PLL_UNLOCK[pll] && pll_mask[pll][0];
  // a free-run profile keeps the loop in holdover while outer bit 7 stays set
  wire ho_now = PLL_HOLDOVER[pll] || outer[pll][cfg_bank_pkg::FREE_RUN_BIT];
  wire ho_bit = ho_sel[pll] == cfg_bank_pkg::HO_VIEW && ho_now;

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    if (!addr_ok) rd_ok = 1'b0;
    else if (idx == cfg_bank_pkg::IX_PAGE) rd_val = page;
    else if (!pg_ok) rd_ok = 1'b0;
    else if (idx == cfg_bank_pkg::IX_STATE_SEL) rd_val = state_sel[slot];
    else if (idx == cfg_bank_pkg::IX_STATE) rd_val = state_rd;
    else if (idx == cfg_bank_pkg::IX_COMMIT) rd_val = 8'h00;
    else if (on_m && idx == cfg_bank_pkg::IX_LIVE_B) rd_val = m_ev;
    else if (on_m && idx == cfg_bank_pkg::IX_STICKY) rd_val = m_sticky;
    else if (on_m && idx == cfg_bank_pkg::IX_MASK_B) rd_val = m_mask;
    else if (on_cm && idx == cfg_bank_pkg::IX_LIVE)
      rd_val = {4'h0, CLOCK_LOSS};
    else if (on_cm && idx == cfg_bank_pkg::IX_CL_STICKY)
      rd_val = {4'h0, cl_sticky};
    else if (on_cm && idx == cfg_bank_pkg::IX_MASK_A)
      rd_val = {4'h0, cl_mask};
    else if (on_cm && idx == cfg_bank_pkg::IX_LIVE_B) rd_val = dr_ev;
    else if (on_cm && idx == cfg_bank_pkg::IX_STICKY) rd_val = dr_sticky;
    else if (on_cm && idx == cfg_bank_pkg::IX_MASK_B) rd_val = dr_mask;
    else if (on_pll && idx == cfg_bank_pkg::IX_LIVE)
      rd_val = {7'h00, lol_live};
    else if (on_pll && idx == cfg_bank_pkg::IX_MASK_A) rd_val = pll_mask[pll];
    else if (on_pll && idx == cfg_bank_pkg::IX_OUTER)
      rd_val = outer[pll];
    else if (on_pll && idx == cfg_bank_pkg::IX_HO_SEL) rd_val = ho_sel[pll];
    else if (on_pll && idx == cfg_bank_pkg::IX_HO_STAT)
      rd_val = {4'h0, ho_bit, 3'h0};
    else rd_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // APB answer: one wait state, data and error registered
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= take;
      if (take) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_val};
        PSLVERR <= !rd_ok;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      page <= cfg_bank_pkg::PG_MASTER;
      m_mask <= cfg_bank_pkg::RESET_VAL;
      cl_mask <= 4'h0;
      dr_mask <= cfg_bank_pkg::RESET_VAL;
      m_sticky <= cfg_bank_pkg::RESET_VAL;
      cl_sticky <= 4'h0;
      dr_sticky <= cfg_bank_pkg::RESET_VAL;
    end else begin
      if (w_page) page <= wd;
      if (w_m_mask) m_mask <= wd;
      if (w_cl_mask) cl_mask <= wd[3:0];
      if (w_dr_mask) dr_mask <= wd;
      m_sticky <= next_m_sticky;
      cl_sticky <= next_cl_sticky[3:0];
      dr_sticky <= next_dr_sticky;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) state_sel[i] <= cfg_bank_pkg::RESET_VAL;
      for (int i = 0; i < 4; i++) begin
        pll_mask[i] <= cfg_bank_pkg::RESET_VAL;
        outer[i] <= cfg_bank_pkg::RESET_VAL;
        ho_sel[i] <= cfg_bank_pkg::RESET_VAL;
      end
    end else begin
      if (w_sel) state_sel[slot] <= wd;
      if (w_p_mask) pll_mask[pll] <= wd;
      if (w_outer) outer[pll] <= wd;
      if (w_ho_sel) ho_sel[pll] <= wd;
    end
  end

  // nonvolatile load window before the master wakes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      load_cnt <= 12'h000;
      load_done <= 1'b0;
    end else if (!load_done) begin
      load_cnt <= load_cnt + 12'h001;
      load_done <= load_cnt == 12'(cfg_bank_pkg::NVM_LOAD_CYC - 1);
    end
  end

  // ---------------------------------------------------------------
  // subsystem sequencers
  // ---------------------------------------------------------------
  ss_ctl_if ctl [8] ();
  for (genvar g = 0; g < 8; g++) begin : g_ss
    // slaves come up once the master has left idle
    if (g == 0) begin : g_m
      assign ctl[g].wake = load_done;
    end else begin : g_s
      assign ctl[g].wake = st[0] != cfg_bank_pkg::SS_IDLE;
    end
    assign ctl[g].commit = w_commit && wd[0] && slot == 3'(g);
    assign st[g] = ctl[g].state;
    subsystem_fsm u_fsm (
      .clk(CLK),
      .rst_n(RST_N),
      .ctl(ctl[g])
    );
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) SUBSYS_POWERED <= 8'h00;
    else begin
      for (int i = 0; i < 8; i++)
        SUBSYS_POWERED[i] <= st[i] != cfg_bank_pkg::SS_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  wire rd_done = PSEL && PENABLE && PREADY && !PWRITE && addr_ok;

  page_switch_a: assert property (w_page |=> page == $past(wd))
    else $error("page select write not applied");
  page_read_a: assert property (rd_done && idx == cfg_bank_pkg::IX_PAGE
    && $stable(page) |-> PRDATA[7:0] == page)
    else $error("page readback wrong");
  master_state_a: assert property (rd_done && on_m
    && idx == cfg_bank_pkg::IX_STATE && $past(take)
    && state_sel[0] == cfg_bank_pkg::SEL_GENERIC
    && $past(st[0]) == cfg_bank_pkg::SS_ACTIVE
    |-> PRDATA[7:0] == cfg_bank_pkg::ST_M_ACT)
    else $error("master active code wrong");
  pll_state_a: assert property (rd_done && on_pll
    && idx == cfg_bank_pkg::IX_STATE
    && state_sel[slot] != cfg_bank_pkg::SEL_PLL
    |-> PRDATA[7:0] == cfg_bank_pkg::ST_IDLE)
    else $error("state shown under wrong selector");
  slave_wake_a: assert property ($rose(st[0] == cfg_bank_pkg::SS_PROG_WAIT)
    |=> st[3] != cfg_bank_pkg::SS_IDLE ##1 SUBSYS_POWERED[3])
    else $error("output subsystem not powered with master");
  notify_clear_a: assert property (w_m_clr && wd == 8'hFF
    && (m_ev & m_mask) == 8'h00 |=> m_sticky == 8'h00)
    else $error("lock and holdover notifies not cleared");
  set_wins_a: assert property (w_cl_clr && CLOCK_LOSS[0] && cl_mask[0]
    |=> cl_sticky[0])
    else $error("clock loss event lost to clear");
  drift_clear_a: assert property (w_dr_clr && (dr_ev & dr_mask) == 8'h00
    |=> (dr_sticky & $past(wd)) == 8'h00)
    else $error("drift notifies not cleared");
  mask_gate_a: assert property (m_mask == 8'h00 && m_sticky == 8'h00
    |=> m_sticky == 8'h00)
    else $error("notify set while masked");
  lock_live_a: assert property (rd_done && on_pll && $past(take)
    && idx == cfg_bank_pkg::IX_LIVE
    |-> PRDATA[0] == $past(lol_live))
    else $error("lock live bit wrong");
  holdover_a: assert property (rd_done && on_pll && $past(take)
    && idx == cfg_bank_pkg::IX_HO_STAT && $stable(ho_sel[pll])
    && ho_sel[pll] == cfg_bank_pkg::HO_VIEW
    && outer[pll][cfg_bank_pkg::FREE_RUN_BIT]
    |-> PRDATA[cfg_bank_pkg::HO_BIT])
    else $error("free run not shown as holdover");
endmodule : config_bank

/* verification/host_model.sv */
// host-side partner: APB master issuing single register transfers
// assumes the bank raises PREADY for every request within bounded time
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // ------------------------------------------------------------
  // transfers
  // ------------------------------------------------------------
  // an idle cycle after each transfer: no strobe set twice in a step
  task automatic xfer(input logic w, input logic [7:0] ix,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic er);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : xfer
  // nonvolatile load must be over before configuring
  task automatic wait_load;
    repeat (cfg_bank_pkg::NVM_LOAD_CYC + 8) @(posedge clk);
  endtask : wait_load
endmodule : host_model

/* verification/testbench.sv */
// self-checking bench of the paged configuration bank
// assumes host_model drives the APB side, events driven here
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0] pg;
    logic [7:0] sel;
    logic [7:0] wt;
    logic [7:0] ac;
  } row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] unlock, holdover, loss, fine, coarse;
  logic [7:0] powered;
  int errors = 0;
  int compares = 0;
  // bring-up order with inputs engaged and all four PLLs used
  row_t rows[8] = '{
    '{8'h00, 8'h40, 8'h09, 8'h24}, '{8'h02, 8'h40, 8'h07, 8'h17},
    '{8'h01, 8'h40, 8'h05, 8'h0C}, '{8'h03, 8'h60, 8'h0C, 8'h14},
    '{8'h0A, 8'h20, 8'h08, 8'h30}, '{8'h0B, 8'h20, 8'h08, 8'h30},
    '{8'h0C, 8'h20, 8'h08, 8'h30}, '{8'h0D, 8'h20, 8'h08, 8'h30}};

  config_bank dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PLL_UNLOCK(unlock), .PLL_HOLDOVER(holdover), .CLOCK_LOSS(loss),
    .DRIFT_FINE(fine), .DRIFT_COARSE(coarse), .SUBSYS_POWERED(powered));
  host_model host_u (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    host_u.xfer(1'h1, ix, d, rdat, rerr);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] ix,
                     input logic [7:0] e);
    host_u.xfer(1'h0, ix, 8'h00, rdat, rerr);
    check(n, rdat, {24'h000000, e});
  endtask : rdc
  task automatic rderr(input logic [7:0] ix);
    host_u.xfer(1'h0, ix, 8'h00, rdat, rerr);
    check("error", {31'h00000000, rerr}, 32'h00000001);
    check("errdata", rdat, 32'h00000000);
  endtask : rderr
  // select a page, see program wait, commit, see active
  task automatic bring_up(input row_t r);
    wr(8'hFF, r.pg);
    rdc("page", 8'hFF, r.pg);
    wr(8'hD1, r.sel);
    rdc("wait", 8'hD0, r.wt);
    wr(8'h30, 8'h01);
    rdc("active", 8'hD0, r.ac);
  endtask : bring_up
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // whole run is near 2500 cycles, two nonvolatile loads included
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'h0;
    {unlock, holdover, loss, fine, coarse} = 20'h00000;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check("powered", {24'h000000, powered}, 32'h00000000);
    rdc("page", 8'hFF, 8'h00);
    rdc("sticky", 8'h07, 8'h00);
    wr(8'hD1, 8'h40);
    rdc("idle", 8'hD0, 8'h00);
    host_u.wait_load();
    check("powered", {24'h000000, powered}, 32'h000000FF);
    foreach (rows[i]) bring_up(rows[i]);
    // lock status seen only once the mask bit is set
    wr(8'hFF, 8'h0A);
    unlock <= 4'h1;
    rdc("lockmask", 8'h02, 8'h00);
    wr(8'h04, 8'h01);
    rdc("unlocked", 8'h02, 8'h01);
    unlock <= 4'h0;
    @(posedge clk);
    rdc("locked", 8'h02, 8'h00);
    wr(8'hFF, 8'h0B);
    wr(8'h17, 8'h80);
    rdc("freerun", 8'h17, 8'h80);
    wr(8'hB3, 8'h0D);
    rdc("hofree", 8'hB9, 8'h08);
    wr(8'h17, 8'h00);
    rdc("hooff", 8'hB9, 8'h00);
    holdover <= 4'h2;
    @(posedge clk);
    rdc("hoon", 8'hB9, 8'h08);
    wr(8'hB3, 8'h0C);
    rdc("hoview", 8'hB9, 8'h00);
    // sticky bits: masked off first, then set, zero write, one write
    wr(8'hFF, 8'h00);
    unlock <= 4'h1;
    holdover <= 4'h8;
    repeat (3) @(posedge clk);
    rdc("nomask", 8'h07, 8'h00);
    wr(8'h08, 8'hFF);
    unlock <= 4'h0;
    holdover <= 4'h0;
    rdc("lolho", 8'h07, 8'h81);
    wr(8'h07, 8'h00);
    rdc("keep", 8'h07, 8'h81);
    wr(8'h07, 8'hFF);
    rdc("clear", 8'h07, 8'h00);
    wr(8'hFF, 8'h01);
    wr(8'h04, 8'h0F);
    loss <= 4'hA;
    repeat (2) @(posedge clk);
    loss <= 4'h0;
    rdc("loss", 8'h03, 8'h0A);
    wr(8'h03, 8'h0F);
    rdc("lossclr", 8'h03, 8'h00);
    // event still present while the clear lands: the set must win
    loss <= 4'h1;
    @(posedge clk);
    wr(8'h03, 8'h0F);
    rdc("losswins", 8'h03, 8'h01);
    loss <= 4'h0;
    wr(8'h03, 8'h0F);
    rdc("lossgone", 8'h03, 8'h00);
    wr(8'h08, 8'hFF);
    fine <= 4'h3;
    coarse <= 4'h4;
    repeat (2) @(posedge clk);
    fine <= 4'h0;
    coarse <= 4'h0;
    rdc("drift", 8'h07, 8'h43);
    wr(8'h07, 8'hFF);
    rdc("driftclr", 8'h07, 8'h00);
    // undecoded page keeps its value but refuses other registers
    wr(8'hFF, 8'h05);
    rdc("badpage", 8'hFF, 8'h05);
    rderr(8'hD0);
    wr(8'hFF, 8'h00);
    rderr(8'h99);
    wr(8'hFF, 8'h0A);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    check("powered", {24'h000000, powered}, 32'h00000000);
    rst_n <= 1'h1;
    @(posedge clk);
    rdc("page", 8'hFF, 8'h00);
    // free-run profile with PLL A only: input and monitor left alone
    host_u.wait_load();
    bring_up(rows[0]);
    bring_up(rows[3]);
    bring_up(rows[4]);
    wr(8'hFF, 8'h0B);
    wr(8'hD1, 8'h20);
    rdc("unused", 8'hD0, 8'h08);
    wr(8'hD1, 8'h40);
    rdc("wrongsel", 8'hD0, 8'h00);
    tally_and_finish();
  end
endmodule : testbench
